// *** logic/adcc_defs.svh ***
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define ADCC_OFF_CTRL_MAIN 8'h00
`define ADCC_OFF_CTRL_FORMAT 8'h04
`define ADCC_OFF_RESULT_HIGH 8'h08
`define ADCC_OFF_RESULT_LOW 8'h0c
`define ADCC_OFF_IRQ_FLAGS 8'h10
`define ADCC_OFF_IRQ_ENABLES 8'h14
`define ADCC_OFF_IRQ_PRIORITY 8'h18
`define ADCC_OFF_PORT_DATA 8'h1c

// ****************************************************
// Field positions
// ****************************************************
`define ADCC_MAIN_CS_MSB 7
`define ADCC_MAIN_CS_LSB 6
`define ADCC_MAIN_CH_MSB 5
`define ADCC_MAIN_CH_LSB 3
`define ADCC_MAIN_GO 2
`define ADCC_MAIN_ON 0
`define ADCC_FMT_RIGHT 7
`define ADCC_FMT_CS2 6
`define ADCC_FMT_PCFG_MSB 3
`define ADCC_FMT_PCFG_LSB 0
`define ADCC_FLAG_DONE 6

// ****************************************************
// Reset values and masks
// ****************************************************
`define ADCC_RST_BYTE 8'h00
`define ADCC_MAIN_WMASK 8'hf9
`define ADCC_FMT_WMASK 8'hcf
`define ADCC_RC_CODE 2'h3
`define ADCC_TRIG_MODE 4'hb

// ****************************************************
// Timing
// ****************************************************
`define ADCC_CLK_NS 4
`define ADCC_RC_TAD_NS 4000
`define ADCC_CONV_TADS 4'hc
`define ADCC_ABORT_TADS 4'h2

`endif

// *** logic/adcc_pkg.sv ***
`default_nettype none

package adcc_pkg;
   // Conversion sequencer states, one-hot
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_conv = 3'b010,
      st_abort = 3'b100
   } adcc_state_t;
endpackage

`default_nettype wire

// *** logic/adcc_top.sv ***
// How it works
// - Conversion lasts exactly twelve bit periods
// - Select code picks divider or RC
// - RC option gives 2-6us bit period
// - Analog-configured pins read as zero
// - Selected pin converted whatever its direction
// - Clearing go mid-conversion aborts at once
// - Abort leaves result pair untouched
// - Abort waits two periods, then reacquires if still on
// - Completion loads result into pair
// - Format bit justifies, unused bits zero
// - Result registers are plain storage otherwise
// - Compare trigger sets go when on and idle
// - Trigger clears the timer counter
// - Trigger ignored while off, timer still cleared
// - Results not reset; control resets zero
// - Completion clears go, sets done flag
// - Reset switches off and aborts
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_top #(
   parameter int ADDR_W = 8,
   parameter logic [15:0] RC_TAD_CYCLES = 16'(`ADCC_RC_TAD_NS / `ADCC_CLK_NS)
) (
   input wire logic pclk, // 250 MHz clock
   input wire logic presetn, // Async reset
   input wire logic clk_en, // Freezes all state when low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [ADDR_W-1:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [9:0] sar_result, // Core result bits
   input wire logic [7:0] port_pins, // Digital pin levels
   input wire logic special_event_trig, // Compare unit event pulse
   input wire logic [3:0] compare_mode_field, // Compare unit mode
   output logic acquire_en, // Sample switch closed
   output logic conv_busy, // Conversion running
   output logic tad_strobe, // One pulse per bit period
   output logic [2:0] analog_channel, // Channel to sample
   output logic timer_clear // Clear timer counter pulse
);

   // ****************************************************
   // Helper functions
   // ****************************************************

   // Bit period in pclk cycles for a select code
   function automatic logic [15:0] tad_cycles(input logic [1:0] low, input logic hi, input logic [15:0] rc);
      logic [15:0] d;
      d = 16'h0002;
      if (low == `ADCC_RC_CODE) begin
         d = rc;
      end else begin
         d = 16'h0002 << {low, 1'b0} << hi;
      end
      return d;
   endfunction

   // Pins acting as analog inputs per config code
   function automatic logic [7:0] analog_pins(input logic [3:0] cfg);
      logic [7:0] m;
      m = 8'h00;
      case (cfg)
         4'h0, 4'h1, 4'h8: m = 8'hff;
         4'h2, 4'h3, 4'hc: m = 8'h1f;
         4'h4, 4'h5: m = 8'h0b;
         4'h9, 4'ha, 4'hb: m = 8'h3f;
         4'hd: m = 8'h0f;
         4'he: m = 8'h01;
         4'hf: m = 8'h0d;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // Justify result into the sixteen bit pair
   function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
      logic [15:0] v;
      v = {r, 6'h00};
      if (right) begin
         v = {6'h00, r};
      end
      return v;
   endfunction

   // ****************************************************
   // State
   // ****************************************************
   adcc_pkg::adcc_state_t state;
   adcc_pkg::adcc_state_t next_state;
   logic [7:0] ctrl_main;
   logic [7:0] ctrl_format;
   logic [7:0] result_high;
   logic [7:0] result_low;
   logic [7:0] irq_flags;
   logic [7:0] irq_enables;
   logic [7:0] irq_priority;
   logic [15:0] tad_cnt;
   logic [15:0] cur_div;
   logic [3:0] period_cnt;
   logic [15:0] phase_cyc;

   // ****************************************************
   // Decode
   // ****************************************************
   logic acc;
   logic wr;
   logic wr_main;
   logic converter_on;
   logic tad_tick;
   logic trig_hit;
   logic start;
   logic abort;
   logic done;
   logic abort_end;
   logic [15:0] sel_div;

   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign wr_main = wr && (paddr == ADDR_W'(`ADCC_OFF_CTRL_MAIN));
   assign converter_on = ctrl_main[`ADCC_MAIN_ON];
   assign sel_div = tad_cycles(ctrl_main[`ADCC_MAIN_CS_MSB:`ADCC_MAIN_CS_LSB], ctrl_format[`ADCC_FMT_CS2],
                               RC_TAD_CYCLES);
   assign tad_tick = (state != adcc_pkg::st_idle) && (tad_cnt == cur_div - 16'h0001);
   assign trig_hit = special_event_trig && (compare_mode_field == `ADCC_TRIG_MODE);
   // Old on bit gates go, so an enable+go write does not start
   assign start = (state == adcc_pkg::st_idle) && converter_on &&
                  ((wr_main && pwdata[`ADCC_MAIN_GO]) || trig_hit);
   // Clearing go or the on bit mid-conversion kills it
   assign abort = (state == adcc_pkg::st_conv) && wr_main &&
                  (!pwdata[`ADCC_MAIN_GO] || !pwdata[`ADCC_MAIN_ON]);
   assign done = (state == adcc_pkg::st_conv) && !abort && tad_tick &&
                 (period_cnt == `ADCC_CONV_TADS - 4'h1);
   assign abort_end = (state == adcc_pkg::st_abort) && tad_tick &&
                      (period_cnt == `ADCC_ABORT_TADS - 4'h1);

   // ****************************************************
   // Sequencer
   // ****************************************************

   // Next state of the conversion sequencer
   always_comb begin
      next_state = state;
      case (state)
         adcc_pkg::st_idle: begin
            if (start) begin
               next_state = adcc_pkg::st_conv;
            end
         end
         adcc_pkg::st_conv: begin
            if (abort) begin
               next_state = adcc_pkg::st_abort;
            end else if (done) begin
               next_state = adcc_pkg::st_idle;
            end
         end
         adcc_pkg::st_abort: begin
            if (abort_end) begin
               next_state = adcc_pkg::st_idle;
            end
         end
         default: next_state = adcc_pkg::st_idle;
      endcase
   end

   // State register; reset drops any conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= adcc_pkg::st_idle;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Bit period divider, restarted on start and abort
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tad_cnt <= 16'h0000;
         cur_div <= 16'h0002;
         period_cnt <= 4'h0;
      end else if (clk_en) begin
         if (start) begin
            tad_cnt <= 16'h0000;
            cur_div <= sel_div; // Latched so a mid-run change is harmless
            period_cnt <= 4'h0;
         end else if (abort) begin
            tad_cnt <= 16'h0000;
            period_cnt <= 4'h0;
         end else if (tad_tick) begin
            tad_cnt <= 16'h0000;
            period_cnt <= period_cnt + 4'h1;
         end else if (state != adcc_pkg::st_idle) begin
            tad_cnt <= tad_cnt + 16'h0001;
         end
      end
   end

   // Outputs to the analog core; mux ignores pin direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acquire_en <= 1'b0;
         conv_busy <= 1'b0;
         tad_strobe <= 1'b0;
         analog_channel <= 3'h0;
         timer_clear <= 1'b0;
      end else if (clk_en) begin
         acquire_en <= converter_on && (next_state == adcc_pkg::st_idle);
         conv_busy <= (next_state == adcc_pkg::st_conv);
         tad_strobe <= tad_tick;
         analog_channel <= ctrl_main[`ADCC_MAIN_CH_MSB:`ADCC_MAIN_CH_LSB];
         timer_clear <= trig_hit;
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************

   // Main control; go set by start, cleared by end or abort
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_main <= `ADCC_RST_BYTE;
      end else if (clk_en) begin
         if (wr_main) begin
            ctrl_main <= pwdata[7:0] & `ADCC_MAIN_WMASK & ~(8'h01 << `ADCC_MAIN_GO);
         end
         if (start) begin
            ctrl_main[`ADCC_MAIN_GO] <= 1'b1;
         end else if (done || abort) begin
            ctrl_main[`ADCC_MAIN_GO] <= 1'b0;
         end else if (wr_main) begin
            ctrl_main[`ADCC_MAIN_GO] <= pwdata[`ADCC_MAIN_GO] && ctrl_main[`ADCC_MAIN_GO];
         end
      end
   end

   // Format and interrupt side registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_format <= `ADCC_RST_BYTE;
         irq_enables <= `ADCC_RST_BYTE;
         irq_priority <= `ADCC_RST_BYTE;
      end else if (clk_en && wr) begin
         if (paddr == ADDR_W'(`ADCC_OFF_CTRL_FORMAT)) begin
            ctrl_format <= pwdata[7:0] & `ADCC_FMT_WMASK;
         end else if (paddr == ADDR_W'(`ADCC_OFF_IRQ_ENABLES)) begin
            irq_enables <= pwdata[7:0];
         end else if (paddr == ADDR_W'(`ADCC_OFF_IRQ_PRIORITY)) begin
            irq_priority <= pwdata[7:0];
         end
      end
   end

   // Flags; completion wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flags <= `ADCC_RST_BYTE;
      end else if (clk_en) begin
         if (wr && (paddr == ADDR_W'(`ADCC_OFF_IRQ_FLAGS))) begin
            irq_flags <= pwdata[7:0];
         end
         if (done) begin
            irq_flags[`ADCC_FLAG_DONE] <= 1'b1;
         end
      end
   end

   // Result pair: no reset, so contents survive reset
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         if (done) begin
            {result_high, result_low} <= justify(sar_result, ctrl_format[`ADCC_FMT_RIGHT]);
         end else begin
            if (wr && (paddr == ADDR_W'(`ADCC_OFF_RESULT_HIGH))) begin
               result_high <= pwdata[7:0];
            end
            if (wr && (paddr == ADDR_W'(`ADCC_OFF_RESULT_LOW))) begin
               result_low <= pwdata[7:0];
            end
         end
      end
   end

   // ****************************************************
   // APB answer
   // ****************************************************
   logic [7:0] rd_byte;
   logic rd_hit;

   // Read mux; port data masks analog pins to zero
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (paddr == ADDR_W'(`ADCC_OFF_CTRL_MAIN)) begin
         rd_byte = ctrl_main;
      end else if (paddr == ADDR_W'(`ADCC_OFF_CTRL_FORMAT)) begin
         rd_byte = ctrl_format;
      end else if (paddr == ADDR_W'(`ADCC_OFF_RESULT_HIGH)) begin
         rd_byte = result_high;
      end else if (paddr == ADDR_W'(`ADCC_OFF_RESULT_LOW)) begin
         rd_byte = result_low;
      end else if (paddr == ADDR_W'(`ADCC_OFF_IRQ_FLAGS)) begin
         rd_byte = irq_flags;
      end else if (paddr == ADDR_W'(`ADCC_OFF_IRQ_ENABLES)) begin
         rd_byte = irq_enables;
      end else if (paddr == ADDR_W'(`ADCC_OFF_IRQ_PRIORITY)) begin
         rd_byte = irq_priority;
      end else if (paddr == ADDR_W'(`ADCC_OFF_PORT_DATA)) begin
         rd_byte = port_pins & ~analog_pins(ctrl_format[`ADCC_FMT_PCFG_MSB:`ADCC_FMT_PCFG_LSB]);
      end else begin
         rd_hit = 1'b0;
      end
   end

   // One access cycle: answer is prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !rd_hit;
         if (psel && !penable) begin
            prdata <= {24'h000000, rd_byte};
         end
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************

   // Cycle count of the current conversion or abort wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_cyc <= 16'h0000;
      end else if (clk_en) begin
         phase_cyc <= (start || abort) ? 16'h0000 : phase_cyc + 16'h0001;
      end
   end

   a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && done) |-> (phase_cyc + 16'h0001 == 16'(`ADCC_CONV_TADS) * cur_div))
      else $error("conversion not twelve bit periods");
   a_clock_select: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && start) |=> (cur_div == $past(sel_div)) && (cur_div >= 16'h0002))
      else $error("bit period not taken from select");
   a_port_masked: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable && (paddr == ADDR_W'(`ADCC_OFF_PORT_DATA))) |=>
      ((prdata[7:0] & analog_pins($past(ctrl_format[`ADCC_FMT_PCFG_MSB:`ADCC_FMT_PCFG_LSB]))) == 8'h00))
      else $error("analog pin read as nonzero");
   a_abort_now: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && abort) |=> !conv_busy && !ctrl_main[`ADCC_MAIN_GO] && (state == adcc_pkg::st_abort))
      else $error("abort not immediate");
   a_abort_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && abort) |=> $stable(result_high) && $stable(result_low))
      else $error("abort changed result");
   a_abort_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && abort_end) |-> (phase_cyc + 16'h0001 == 16'(`ADCC_ABORT_TADS) * cur_div) ##1
      (acquire_en || !$past(converter_on)))
      else $error("abort wait wrong");
   a_result_fmt: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && done) |=> ($past(ctrl_format[`ADCC_FMT_RIGHT]) ?
      ({result_high, result_low} == {6'h00, $past(sar_result)}) :
      ({result_high, result_low} == {$past(sar_result), 6'h00})))
      else $error("result not justified");
   a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && done) |=> irq_flags[`ADCC_FLAG_DONE] && !ctrl_main[`ADCC_MAIN_GO] && !conv_busy)
      else $error("completion flags wrong");
   a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && trig_hit && converter_on && state == adcc_pkg::st_idle) |=>
      ctrl_main[`ADCC_MAIN_GO] && conv_busy)
      else $error("trigger did not start");
   a_trig_timer: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && trig_hit) |=> timer_clear)
      else $error("timer not cleared");
   a_trig_off: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && trig_hit && !converter_on && state == adcc_pkg::st_idle) |=> !conv_busy && timer_clear)
      else $error("trigger not ignored while off");

endmodule // adcc_top

`default_nettype wire

// *** verification/adcc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// Sample-and-hold and successive approximation core
// ****************************************************
module adcc_core_model (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset
   input wire logic conv_busy, // Conversion running
   input wire logic [2:0] analog_channel, // Channel to sample
   input wire logic [79:0] pin_levels, // Ten-bit level per pin
   output logic [9:0] sar_result // Result bits
);
   logic [9:0] held;
   logic was_busy;

   // Capacitor frozen at conversion start; pin direction plays no part
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 10'h000;
         was_busy <= 1'b0;
      end else begin
         was_busy <= conv_busy;
         if (conv_busy && !was_busy) begin
            held <= pin_levels[analog_channel * 10 +: 10];
         end
      end
   end

   // Outside a conversion the bits are stale, so show them inverted
   assign sar_result = conv_busy ? held : ~held;
endmodule // adcc_core_model

`default_nettype wire

// *** verification/adcc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_top_test;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, port_pins;
   logic [31:0] pwdata, prdata;
   logic [9:0] sar_result;
   logic special_event_trig, acquire_en, conv_busy, tad_strobe, timer_clear;
   logic [3:0] compare_mode_field;
   logic [2:0] analog_channel;
   logic [79:0] pin_levels;
   int errors = 0;
   int n_tests = 0;
   localparam int RC = 4;
   localparam logic [3:0] CFGS[4] = '{4'h0, 4'h6, 4'he, 4'h2};
   localparam logic [7:0] AMASK[4] = '{8'hff, 8'h00, 8'h01, 8'h1f};
   int n_strobe = 0;

   // Bit period strobes seen so far
   always @(posedge pclk) begin
      if (tad_strobe === 1'b1) n_strobe <= n_strobe + 1;
   end

   adcc_top #(.RC_TAD_CYCLES(16'h0004)) uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sar_result(sar_result), .port_pins(port_pins), .special_event_trig(special_event_trig),
      .compare_mode_field(compare_mode_field), .acquire_en(acquire_en), .conv_busy(conv_busy),
      .tad_strobe(tad_strobe), .analog_channel(analog_channel), .timer_clear(timer_clear));
   adcc_core_model core (.pclk(pclk), .presetn(presetn), .conv_busy(conv_busy),
      .analog_channel(analog_channel), .pin_levels(pin_levels), .sar_result(sar_result));

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; the leading edge keeps releases and new setups apart
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, a, d, rd, e);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] rd;
      logic e;
      apb(1'b0, a, 8'h00, rd, e);
      check(what, rd, {24'h0, exp});
   endtask

   // Bit period in clocks for a three-bit select code
   function automatic int conversion_bit_period(input logic [2:0] cs);
      if (cs[1:0] == 2'b11) return RC;
      return 2 << (cs[1:0] * 2 + cs[2]);
   endfunction

   // Justified halves of a result
   function automatic logic [15:0] just(input logic [9:0] r, input logic right);
      return right ? {6'h00, r} : {r, 6'h00};
   endfunction

   // Waits on the line level sampled before each edge's updates land
   task automatic count_while(ref logic sig, input logic lvl, output int n);
      n = 0;
      forever begin
         @(posedge pclk);
         if (sig !== lvl || n > 3000) break;
         n++;
      end
   endtask

   task automatic convert(input logic [2:0] cs, input logic right, input logic [2:0] ch);
      int n;
      int s;
      logic [15:0] r;
      wr(`ADCC_OFF_CTRL_FORMAT, {right, cs[2], 6'h00});
      wr(`ADCC_OFF_CTRL_MAIN, {cs[1:0], ch, 3'b001});
      repeat (20) @(posedge pclk);
      check("channel", analog_channel, ch);
      r = just(pin_levels[ch * 10 +: 10], right);
      s = n_strobe;
      wr(`ADCC_OFF_CTRL_MAIN, {cs[1:0], ch, 3'b101});
      count_while(conv_busy, 1'b1, n);
      check("busy cycles", n, 12 * conversion_bit_period(cs));
      rd_chk("go cleared", `ADCC_OFF_CTRL_MAIN, {cs[1:0], ch, 3'b001});
      rd_chk("done flag", `ADCC_OFF_IRQ_FLAGS, 8'h40);
      rd_chk("result high", `ADCC_OFF_RESULT_HIGH, r[15:8]);
      rd_chk("result low", `ADCC_OFF_RESULT_LOW, r[7:0]);
      check("bit strobes", n_strobe - s, 32'h0000000c);
      wr(`ADCC_OFF_IRQ_FLAGS, 8'h00);
      repeat (2 * conversion_bit_period(cs) + 2) @(posedge pclk);
      check("sampling", acquire_en, 1'b1);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************************
   // Clock, watchdog and main sequence
   // ****************************************************
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   // Whole run needs well under 20k cycles
   initial begin
      #80000;
      errors++;
      final_report();
   end

   // Scenarios in order
   initial begin
      logic [31:0] v, rd;
      logic e;
      logic [7:0] vh, vl;
      logic [3:0] m;
      int n;
      {presetn, psel, penable, pwrite, special_event_trig} = 5'h00;
      clk_en = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      compare_mode_field = 4'h0;
      void'($urandom(32'h08c3));
      pin_levels = 80'({$urandom, $urandom, $urandom});
      port_pins = 8'($urandom);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // Result pair skipped: it powers up unknown
      for (int i = 0; i < 7; i++) begin
         if (i < 2 || i > 3) rd_chk("reset value", 8'(i * 4), 8'h00);
      end
      apb(1'b0, 8'h20, 8'h00, rd, e);
      check("unmapped error", e, 1'b1);
      check("unmapped data", rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(`ADCC_OFF_RESULT_HIGH, v[7:0]);
         wr(`ADCC_OFF_RESULT_LOW, v[15:8]);
         rd_chk("store high", `ADCC_OFF_RESULT_HIGH, v[7:0]);
         rd_chk("store low", `ADCC_OFF_RESULT_LOW, v[15:8]);
      end
      $display("test reset and storage done");
      wr(`ADCC_OFF_CTRL_MAIN, 8'h05);
      repeat (3) @(posedge pclk);
      check("on with go", conv_busy, 1'b0);
      for (int c = 0; c < 8; c++) convert(3'(c), 1'($urandom), 3'($urandom));
      $display("test conversions done");
      for (int i = 0; i < 4; i++) begin
         wr(`ADCC_OFF_CTRL_FORMAT, {4'h0, CFGS[i]});
         rd_chk("port read", `ADCC_OFF_PORT_DATA, port_pins & ~AMASK[i]);
      end
      $display("test port config done");
      wr(`ADCC_OFF_CTRL_FORMAT, 8'hc0);
      wr(`ADCC_OFF_CTRL_MAIN, 8'h81);
      repeat (20) @(posedge pclk);
      apb(1'b0, `ADCC_OFF_RESULT_HIGH, 8'h00, rd, e);
      vh = rd[7:0];
      apb(1'b0, `ADCC_OFF_RESULT_LOW, 8'h00, rd, e);
      vl = rd[7:0];
      wr(`ADCC_OFF_CTRL_MAIN, 8'h85);
      repeat (100) @(posedge pclk);
      wr(`ADCC_OFF_CTRL_MAIN, 8'h81);
      @(posedge pclk);
      check("abort busy", conv_busy, 1'b0);
      count_while(acquire_en, 1'b0, n);
      check("abort wait", (n >= 127 && n <= 129), 1'b1);
      rd_chk("abort high", `ADCC_OFF_RESULT_HIGH, vh);
      rd_chk("abort low", `ADCC_OFF_RESULT_LOW, vl);
      $display("test abort done");
      wr(`ADCC_OFF_CTRL_FORMAT, 8'h00);
      for (int i = 0; i < 3; i++) begin
         m = 4'($urandom);
         if (i < 2 || m == `ADCC_TRIG_MODE) m = (i < 2) ? `ADCC_TRIG_MODE : 4'h0;
         wr(`ADCC_OFF_CTRL_MAIN, {5'h00, 2'b00, i != 1});
         repeat (20) @(posedge pclk);
         compare_mode_field <= m;
         special_event_trig <= 1'b1;
         @(posedge pclk);
         special_event_trig <= 1'b0;
         @(posedge pclk);
         check("timer clear", timer_clear, m == `ADCC_TRIG_MODE);
         check("trig start", conv_busy, i == 0);
         @(posedge pclk);
         check("clear pulse", timer_clear, 1'b0);
         repeat (40) @(posedge pclk);
         wr(`ADCC_OFF_IRQ_FLAGS, 8'h00);
      end
      $display("test trigger done");
      apb(1'b0, `ADCC_OFF_RESULT_HIGH, 8'h00, rd, e);
      vh = rd[7:0];
      // Software picks the RC option: no divider code reaches the period floor at this clock
      wr(`ADCC_OFF_CTRL_MAIN, 8'hc1);
      repeat (20) @(posedge pclk);
      wr(`ADCC_OFF_CTRL_MAIN, 8'hc5);
      repeat (10) @(posedge pclk);
      // Freeze past the natural end; the conversion must still be running
      clk_en <= 1'b0;
      repeat (60) @(posedge pclk);
      check("frozen busy", conv_busy, 1'b1);
      clk_en <= 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      check("reset busy", conv_busy, 1'b0);
      check("reset sample", acquire_en, 1'b0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("reset off", `ADCC_OFF_CTRL_MAIN, 8'h00);
      rd_chk("result kept", `ADCC_OFF_RESULT_HIGH, vh);
      $display("test mid-run reset done");
      final_report();
   end
endmodule // adcc_top_test

`default_nettype wire
